// File: logic/xcvr_mute_pkg.sv
// constants, register map and carrier types for the output mute control
package xcvr_mute_pkg;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_RX_FREQ = 8'h04;
  localparam logic [7:0] OFS_TX_FREQ = 8'h08;
  localparam logic [7:0] OFS_RX_ATT  = 8'h0C;
  localparam logic [7:0] OFS_TX_ATT  = 8'h10;
  localparam logic [7:0] OFS_RX_GAIN = 8'h14;
  localparam logic [7:0] OFS_TX_GAIN = 8'h18;
  localparam logic [7:0] OFS_RX_TILT = 8'h1C;
  localparam logic [7:0] OFS_TX_TILT = 8'h20;
  localparam logic [7:0] OFS_REF     = 8'h24;
  localparam logic [7:0] OFS_STATUS  = 8'h28;
  localparam logic [7:0] OFS_INT_ST  = 8'h2C;
  localparam logic [7:0] OFS_INT_MSK = 8'h30;

  // ************************************************************
  // control register bits
  // ************************************************************
  localparam int B_MODE    = 0;
  localparam int B_RX_SIL  = 1;
  localparam int B_TX_SIL  = 2;
  localparam int B_PWR     = 3;
  localparam int B_RX_TM   = 4;
  localparam int B_TX_TM   = 5;
  localparam int B_XSEL    = 6;
  localparam int B_WARM    = 7;
  localparam int CTRL_W    = 8;
  // mode=1, both muted, amp off, manual tilt, xsel=0, warm-up on
  localparam logic [7:0] CTRL_RST = 8'h87;

  // ************************************************************
  // value ranges (steps: freq 0.5 MHz, att/gain 0.25 dB, tilt 0.1)
  // ************************************************************
  localparam int FREQ_W   = 16;
  localparam logic [15:0] STEP_1M0 = 16'h0002;
  localparam logic [15:0] STEP_2M5 = 16'h0005;
  localparam logic [15:0] RX_FMIN  = 16'h1CE8; // 3700.0 MHz
  localparam logic [15:0] RX_FMAX  = 16'h1F40; // 4000.0 MHz
  localparam logic [15:0] TX_FMIN  = 16'h2E18; // 5900.0 MHz
  localparam logic [15:0] TX_FMAX  = 16'h3070; // 6200.0 MHz
  localparam logic [15:0] ATT_MAX  = 16'h0064; // 25.00 dB
  localparam logic [15:0] GAIN_MAX = 16'h0010; // 4.00 dB below zero
  localparam logic [15:0] TILT_MAX = 16'h000A; // 1.0
  localparam logic [15:0] REF_MAX  = 16'h00FF;
  localparam logic [7:0]  REF_RST  = 8'h57;    // 087

  // ************************************************************
  // interrupt events and status bits
  // ************************************************************
  localparam int NEV      = 5;
  localparam int EV_RXF   = 0;
  localparam int EV_TXF   = 1;
  localparam int EV_XLOCK = 2;
  localparam int EV_WARM  = 3;
  localparam int EV_REJ   = 4;
  localparam int P_RXF    = 0;
  localparam int P_TXF    = 1;
  localparam int P_XLOCK  = 2;
  localparam int P_STRAP  = 3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PS        = 4000;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYCLES   = TICK_US * 1000 / CLK_PS;
  localparam int HOLDOFF_MIN   = 15;
  localparam int HOLDOFF_TICKS = HOLDOFF_MIN * 60 * 1000000 / TICK_US;

  // calibrated tilt, indexed by frequency bits [9:6]
  localparam logic [63:0] CAL_TILT = 64'h0123_4566_7788_99AA;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [15:0] rx_freq;
    logic [15:0] tx_freq;
    logic [6:0]  rx_att;
    logic [6:0]  tx_att;
    logic [4:0]  rx_gain;
    logic [4:0]  tx_gain;
    logic [3:0]  rx_tilt;
    logic [3:0]  tx_tilt;
    logic [7:0]  ref_trim;
  } setting_t;

  typedef struct packed {
    logic rx_on;
    logic tx_on;
    logic supply_on;
    logic contact_make;
    logic contact_break;
  } drive_t;
endpackage : xcvr_mute_pkg

// File: logic/xcvr_mute_ctrl.sv
// output mute control with APB parameter registers
// Notes on behaviour
// - frequency must be 1.0/2.5 MHz multiple, in range
// - attenuation 0 to 25 dB, 0.25 dB steps
// - gain trim 0 to -4 dB, redundant only
// - mode 1 mutes output after its retune
// - mode 0 keeps prior mute, faults still gate
// - mute-after-retune mode resets to one
// - rx on needs no fault, rx unmuted
// - tx on needs no fault, unmuted, amp on
// - amp off removes power stage supply
// - calibrated tilt from table, else manual value
// - manual tilt 0.0 to 1.0, default 0.0
// - reference trim 0 to 255, default 87
// - option adds external lock loss to alarm
// - warm-up mutes both outputs 900000 ticks of 250 cycles (0.9 s at 4 ns)
// - clearing warm-up ends hold-off at once
// - alarm make closes, break opens on fault
// - open strap stand-alone, grounded strap redundant
`timescale 1ns/10ps
module xcvr_mute_ctrl #(
  parameter int TICK_CYCLES   = xcvr_mute_pkg::TICK_CYCLES,
  parameter int HOLDOFF_TICKS = xcvr_mute_pkg::HOLDOFF_TICKS
) (
  // apb slave
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // hardware status pins
  input  wire logic                   rx_synth_fault,
  input  wire logic                   tx_synth_fault,
  input  wire logic                   ext_lock_loss,
  input  wire logic                   redundancy_strap_n,
  // applied settings and drives
  output xcvr_mute_pkg::setting_t     setting,
  output xcvr_mute_pkg::drive_t       drive,
  output logic                        irq
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0]                ctrl;
    xcvr_mute_pkg::setting_t   sw;
    xcvr_mute_pkg::setting_t   applied;
    xcvr_mute_pkg::drive_t     drv;
    logic [4:0]                int_st;
    logic [4:0]                int_msk;
    logic [31:0]               rdata;
    logic [3:0]                s1;
    logic [3:0]                s2;
    logic [3:0]                s3;
    logic [3:0]                pin;
    logic [3:0]                pin_q;
    logic                      hold;
    logic [17:0]               tick_cnt;
    logic [19:0]               hold_cnt;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);
  localparam logic [19:0] HOLD_LAST = 20'(HOLDOFF_TICKS);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic in_range(input logic [31:0] v,
                                    input logic [15:0] hi);
    in_range = (v[31:16] == 16'h0000) && (v[15:0] <= hi);
  endfunction : in_range

  function automatic logic freq_ok(input logic [31:0] v,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    freq_ok = in_range(v, hi) && (v[15:0] >= lo) &&
              ((v[15:0] % xcvr_mute_pkg::STEP_1M0 == 16'h0000) ||
               (v[15:0] % xcvr_mute_pkg::STEP_2M5 == 16'h0000));
  endfunction : freq_ok

  function automatic logic [3:0] cal_tilt(input logic [15:0] f);
    cal_tilt = xcvr_mute_pkg::CAL_TILT[{f[9:6], 2'b00} +: 4];
  endfunction : cal_tilt

  // ************************************************************
  // decode
  // ************************************************************
  logic        setup;
  logic        wr;
  logic        mapped;
  logic        ok;
  logic [31:0] rd;
  logic        redundant;
  logic        rx_fault;
  logic        tx_fault;
  logic        alarm;
  logic [4:0]  ev;
  logic [4:0]  w1c;

  always_comb begin
    setup = psel && !penable;
    wr = psel && penable && pwrite;
    mapped = 1'b1;
    ok = 1'b1;
    rd = 32'h0000_0000;
    unique case (paddr)
      xcvr_mute_pkg::OFS_CTRL: begin
        ok = (pwdata[31:8] == 24'h00_0000);
        rd = {24'h00_0000, st_r.ctrl};
      end
      xcvr_mute_pkg::OFS_RX_FREQ: begin
        ok = freq_ok(pwdata, xcvr_mute_pkg::RX_FMIN,
                     xcvr_mute_pkg::RX_FMAX);
        rd = {16'h0000, st_r.sw.rx_freq};
      end
      xcvr_mute_pkg::OFS_TX_FREQ: begin
        ok = freq_ok(pwdata, xcvr_mute_pkg::TX_FMIN,
                     xcvr_mute_pkg::TX_FMAX);
        rd = {16'h0000, st_r.sw.tx_freq};
      end
      xcvr_mute_pkg::OFS_RX_ATT: begin
        ok = in_range(pwdata, xcvr_mute_pkg::ATT_MAX);
        rd = {25'h000_0000, st_r.sw.rx_att};
      end
      xcvr_mute_pkg::OFS_TX_ATT: begin
        ok = in_range(pwdata, xcvr_mute_pkg::ATT_MAX);
        rd = {25'h000_0000, st_r.sw.tx_att};
      end
      xcvr_mute_pkg::OFS_RX_GAIN: begin
        ok = in_range(pwdata, xcvr_mute_pkg::GAIN_MAX);
        rd = {27'h000_0000, st_r.sw.rx_gain};
      end
      xcvr_mute_pkg::OFS_TX_GAIN: begin
        ok = in_range(pwdata, xcvr_mute_pkg::GAIN_MAX);
        rd = {27'h000_0000, st_r.sw.tx_gain};
      end
      xcvr_mute_pkg::OFS_RX_TILT: begin
        ok = in_range(pwdata, xcvr_mute_pkg::TILT_MAX);
        rd = {28'h000_0000, st_r.sw.rx_tilt};
      end
      xcvr_mute_pkg::OFS_TX_TILT: begin
        ok = in_range(pwdata, xcvr_mute_pkg::TILT_MAX);
        rd = {28'h000_0000, st_r.sw.tx_tilt};
      end
      xcvr_mute_pkg::OFS_REF: begin
        ok = in_range(pwdata, xcvr_mute_pkg::REF_MAX);
        rd = {24'h00_0000, st_r.sw.ref_trim};
      end
      xcvr_mute_pkg::OFS_STATUS: begin
        ok = 1'b0;
        rd = {22'h00_0000, st_r.hold, st_r.pin, st_r.drv};
      end
      xcvr_mute_pkg::OFS_INT_ST: begin
        rd = {27'h000_0000, st_r.int_st};
      end
      xcvr_mute_pkg::OFS_INT_MSK: begin
        ok = (pwdata[31:5] == 27'h000_0000);
        rd = {27'h000_0000, st_r.int_msk};
      end
      default: begin
        mapped = 1'b0;
        ok = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    ev = 5'h00;
    w1c = 5'h00;

    // pins pass three flops; a change counts once 2nd and 3rd agree
    st_nxt.s1 = {redundancy_strap_n, ext_lock_loss,
                 tx_synth_fault, rx_synth_fault};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.pin_q = st_r.pin;
    for (int i = 0; i < 4; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.pin[i] = st_r.s3[i];
      end
    end
    redundant = !st_r.pin[xcvr_mute_pkg::P_STRAP];
    rx_fault = st_r.pin[xcvr_mute_pkg::P_RXF];
    tx_fault = st_r.pin[xcvr_mute_pkg::P_TXF];

    // register writes
    if (setup) begin
      st_nxt.rdata = rd;
    end
    if (wr && mapped && !ok) begin
      ev[xcvr_mute_pkg::EV_REJ] = 1'b1;
    end
    if (wr && ok) begin
      unique case (paddr)
        xcvr_mute_pkg::OFS_CTRL: begin
          st_nxt.ctrl = pwdata[7:0];
        end
        xcvr_mute_pkg::OFS_RX_FREQ: begin
          st_nxt.sw.rx_freq = pwdata[15:0];
          // mode 0 leaves the mute bit as it was; faults still gate
          if (st_r.ctrl[xcvr_mute_pkg::B_MODE] &&
              pwdata[15:0] != st_r.sw.rx_freq) begin
            st_nxt.ctrl[xcvr_mute_pkg::B_RX_SIL] = 1'b1;
          end
        end
        xcvr_mute_pkg::OFS_TX_FREQ: begin
          st_nxt.sw.tx_freq = pwdata[15:0];
          if (st_r.ctrl[xcvr_mute_pkg::B_MODE] &&
              pwdata[15:0] != st_r.sw.tx_freq) begin
            st_nxt.ctrl[xcvr_mute_pkg::B_TX_SIL] = 1'b1;
          end
        end
        xcvr_mute_pkg::OFS_RX_ATT: st_nxt.sw.rx_att = pwdata[6:0];
        xcvr_mute_pkg::OFS_TX_ATT: st_nxt.sw.tx_att = pwdata[6:0];
        xcvr_mute_pkg::OFS_RX_GAIN: st_nxt.sw.rx_gain = pwdata[4:0];
        xcvr_mute_pkg::OFS_TX_GAIN: st_nxt.sw.tx_gain = pwdata[4:0];
        xcvr_mute_pkg::OFS_RX_TILT: st_nxt.sw.rx_tilt = pwdata[3:0];
        xcvr_mute_pkg::OFS_TX_TILT: st_nxt.sw.tx_tilt = pwdata[3:0];
        xcvr_mute_pkg::OFS_REF: st_nxt.sw.ref_trim = pwdata[7:0];
        xcvr_mute_pkg::OFS_INT_ST: w1c = pwdata[4:0];
        xcvr_mute_pkg::OFS_INT_MSK: st_nxt.int_msk = pwdata[4:0];
        default: ;
      endcase
    end

    // warm-up hold-off; a tick divider keeps the counter narrow
    if (st_r.hold) begin
      if (st_r.tick_cnt == TICK_LAST) begin
        st_nxt.tick_cnt = 18'h0_0000;
        st_nxt.hold_cnt = st_r.hold_cnt + 20'h0_0001;
      end else begin
        st_nxt.tick_cnt = st_r.tick_cnt + 18'h0_0001;
      end
      if (!st_r.ctrl[xcvr_mute_pkg::B_WARM] ||
          st_r.hold_cnt == HOLD_LAST) begin
        st_nxt.hold = 1'b0;
        ev[xcvr_mute_pkg::EV_WARM] = 1'b1;
      end
    end

    // output drives
    st_nxt.drv.rx_on = !rx_fault && !st_r.hold &&
                       !st_r.ctrl[xcvr_mute_pkg::B_RX_SIL];
    st_nxt.drv.tx_on = !tx_fault && !st_r.hold &&
                       !st_r.ctrl[xcvr_mute_pkg::B_TX_SIL] &&
                       st_r.ctrl[xcvr_mute_pkg::B_PWR];
    // supply follows the amp bit alone, whatever the mute state
    st_nxt.drv.supply_on = st_r.ctrl[xcvr_mute_pkg::B_PWR];
    alarm = rx_fault || tx_fault ||
            (st_r.ctrl[xcvr_mute_pkg::B_XSEL] &&
             st_r.pin[xcvr_mute_pkg::P_XLOCK]);
    st_nxt.drv.contact_make = alarm;
    st_nxt.drv.contact_break = !alarm;

    // applied settings
    st_nxt.applied = st_r.sw;
    if (!redundant) begin
      st_nxt.applied.rx_gain = 5'h00;
      st_nxt.applied.tx_gain = 5'h00;
    end
    if (st_r.ctrl[xcvr_mute_pkg::B_RX_TM]) begin
      st_nxt.applied.rx_tilt = cal_tilt(st_r.sw.rx_freq);
    end
    if (st_r.ctrl[xcvr_mute_pkg::B_TX_TM]) begin
      st_nxt.applied.tx_tilt = cal_tilt(st_r.sw.tx_freq);
    end

    // sticky events; a set in the clearing cycle wins
    ev[xcvr_mute_pkg::EV_RXF] = rx_fault &&
                                !st_r.pin_q[xcvr_mute_pkg::P_RXF];
    ev[xcvr_mute_pkg::EV_TXF] = tx_fault &&
                                !st_r.pin_q[xcvr_mute_pkg::P_TXF];
    ev[xcvr_mute_pkg::EV_XLOCK] = st_r.pin[xcvr_mute_pkg::P_XLOCK] &&
                                  !st_r.pin_q[xcvr_mute_pkg::P_XLOCK];
    st_nxt.int_st = (st_r.int_st & ~w1c) | ev;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.ctrl <= xcvr_mute_pkg::CTRL_RST;
      st_r.sw.rx_freq <= xcvr_mute_pkg::RX_FMIN;
      st_r.sw.tx_freq <= xcvr_mute_pkg::TX_FMIN;
      st_r.sw.ref_trim <= xcvr_mute_pkg::REF_RST;
      st_r.applied.rx_freq <= xcvr_mute_pkg::RX_FMIN;
      st_r.applied.tx_freq <= xcvr_mute_pkg::TX_FMIN;
      st_r.applied.ref_trim <= xcvr_mute_pkg::REF_RST;
      st_r.drv.contact_break <= 1'b1;
      st_r.pin <= 4'h8;
      st_r.pin_q <= 4'h8;
      // chain starts at the idle pin levels, else an open strap reads
      // as grounded for a few cycles after reset
      st_r.s1 <= 4'h8;
      st_r.s2 <= 4'h8;
      st_r.s3 <= 4'h8;
      st_r.hold <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata  = st_r.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (!mapped || (pwrite && !ok));
  assign setting = st_r.applied;
  assign drive   = st_r.drv;
  assign irq     = |(st_r.int_st & st_r.int_msk);
endmodule : xcvr_mute_ctrl

// File: dv/xcvr_mute_checker.sv
// concurrent checks on the ports of the output mute control
`timescale 1ns/10ps
module xcvr_mute_checker #(
  parameter int TICK_CYCLES   = 4,
  parameter int HOLDOFF_TICKS = 5
) (
  // apb side
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // pins
  input wire logic                    rx_synth_fault,
  input wire logic                    tx_synth_fault,
  input wire logic                    redundancy_strap_n,
  // applied values
  input wire xcvr_mute_pkg::setting_t setting,
  input wire xcvr_mute_pkg::drive_t   drive
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ************************************************************
  // write steps
  // ************************************************************
  sequence wr_to(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  sequence bad_att;
    wr_to(xcvr_mute_pkg::OFS_RX_ATT) ##0 (pwdata > 32'h0000_0064);
  endsequence
  sequence odd_freq;
    wr_to(xcvr_mute_pkg::OFS_RX_FREQ) ##0 (pwdata == 32'h0000_1CE9);
  endsequence

  a_access_ready: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_contact_pair: assert property (drive.contact_make != drive.contact_break)
    else $error("alarm contacts not complementary");
  a_tx_supply: assert property (drive.tx_on |-> drive.supply_on)
    else $error("tx output on without supply");
  a_rx_fault_mute: assert property (rx_synth_fault [*8] |-> !drive.rx_on)
    else $error("rx output on during fault");
  a_tx_fault_mute: assert property (tx_synth_fault [*8] |-> !drive.tx_on)
    else $error("tx output on during fault");
  a_gain_alone: assert property (redundancy_strap_n [*8] |->
      setting.rx_gain == 5'h00 && setting.tx_gain == 5'h00)
    else $error("gain trim applied while stand-alone");
  a_tilt_range: assert property (setting.rx_tilt <= 4'hA &&
      setting.tx_tilt <= 4'hA)
    else $error("tilt beyond full scale");
  a_att_refuse: assert property (bad_att |-> pslverr ##2
      $stable(setting.rx_att))
    else $error("bad attenuation accepted");
  a_freq_refuse: assert property (odd_freq |-> pslverr ##2
      $stable(setting.rx_freq))
    else $error("off-step frequency accepted");
endmodule : xcvr_mute_checker

bind xcvr_mute_ctrl xcvr_mute_checker #(
  .TICK_CYCLES(TICK_CYCLES),
  .HOLDOFF_TICKS(HOLDOFF_TICKS)
) checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .rx_synth_fault(rx_synth_fault),
  .tx_synth_fault(tx_synth_fault),
  .redundancy_strap_n(redundancy_strap_n), .setting(setting),
  .drive(drive));

// File: dv/xcvr_status_model.sv
// status pin model of the transceiver hardware around the block
`timescale 1ns/10ps
module xcvr_status_model (
  // requested conditions
  input  wire logic rx_bad,
  input  wire logic tx_bad,
  input  wire logic ref_unlock,
  input  wire logic strap_gnd,
  // pins toward the block
  output logic      rx_synth_fault,
  output logic      tx_synth_fault,
  output logic      ext_lock_loss,
  output logic      redundancy_strap_n
);
  assign rx_synth_fault = rx_bad;
  assign tx_synth_fault = tx_bad;
  assign ext_lock_loss  = ref_unlock;
  // an open strap floats high through its pull-up
  assign redundancy_strap_n = !strap_gnd;
endmodule : xcvr_status_model

// File: dv/xcvr_mute_ctrl_test.sv
// self-checking bench for the output mute control
`timescale 1ns/10ps
module xcvr_mute_ctrl_test;
  typedef struct { logic [7:0] a; logic [15:0] d; logic e; } wr_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, old;
  logic pready, pslverr, irq, err, rxf, txf, xll, strap_n;
  logic rx_bad = 0, tx_bad = 0, ref_unlock = 0, strap_gnd = 0;
  xcvr_mute_pkg::setting_t setting;
  xcvr_mute_pkg::drive_t drive;
  int mismatches = 0, n_compared = 0, cyc = 0, rel = 0;

  always #2 pclk = ~pclk;

  xcvr_status_model far (.rx_bad(rx_bad), .tx_bad(tx_bad),
    .ref_unlock(ref_unlock), .strap_gnd(strap_gnd), .rx_synth_fault(rxf),
    .tx_synth_fault(txf), .ext_lock_loss(xll), .redundancy_strap_n(strap_n));
  xcvr_mute_ctrl #(.TICK_CYCLES(4), .HOLDOFF_TICKS(5)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_synth_fault(rxf), .tx_synth_fault(txf),
    .ext_lock_loss(xll), .redundancy_strap_n(strap_n), .setting(setting),
    .drive(drive), .irq(irq));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_holdoff();
    apb(xcvr_mute_pkg::OFS_CTRL, 0, 0);
    chk("ctrl reset", 32'h0000_0087, rd);
    apb(xcvr_mute_pkg::OFS_REF, 0, 0);
    chk("ref reset", 32'h0000_0057, rd);
    chk("tilt reset", 32'h0000_0000, 32'({setting.rx_tilt, setting.tx_tilt}));
    apb(xcvr_mute_pkg::OFS_CTRL, 1, 32'h0000_0089);
    chk("rx held", 32'h0000_0000, 32'(drive.rx_on));
    for (int i = 0; i < 80 && drive.rx_on !== 1'b1; i++) @(posedge pclk);
    chk("hold-off length", 32'h0000_0001, 32'(cyc - rel >= 20));
    chk("outputs on", 32'h0000_0007,
        32'({drive.rx_on, drive.tx_on, drive.supply_on}));
    $display("holdoff done");
  endtask : t_holdoff

  task automatic t_retune();
    apb(xcvr_mute_pkg::OFS_RX_FREQ, 1, 32'h0000_1CEA);
    apb(xcvr_mute_pkg::OFS_CTRL, 0, 0);
    chk("retune mutes", 32'h0000_008B, rd);
    chk("rx muted", 32'h0000_0000, 32'(drive.rx_on));
    apb(xcvr_mute_pkg::OFS_CTRL, 1, 32'h0000_0088);
    apb(xcvr_mute_pkg::OFS_RX_FREQ, 1, 32'h0000_1CF2);
    tick(3);
    apb(xcvr_mute_pkg::OFS_CTRL, 0, 0);
    chk("mode 0 keeps", 32'h0000_0088, rd);
    chk("rx stays on", 32'h0000_0001, 32'(drive.rx_on));
    apb(xcvr_mute_pkg::OFS_CTRL, 1, 32'h0000_00B8);
    tick(2);
    chk("cal tilt", 32'(xcvr_mute_pkg::CAL_TILT[15:12]),
        32'(setting.rx_tilt));
    chk("cal tx tilt", 32'(xcvr_mute_pkg::CAL_TILT[35:32]),
        32'(setting.tx_tilt));
    apb(xcvr_mute_pkg::OFS_RX_TILT, 1, 32'h0000_0007);
    apb(xcvr_mute_pkg::OFS_CTRL, 1, 32'h0000_0088);
    tick(2);
    chk("manual tilt", 32'h0000_0007, 32'(setting.rx_tilt));
    $display("retune done");
  endtask : t_retune

  task automatic t_refuse();
    wr_t tw[13] = '{
      '{xcvr_mute_pkg::OFS_RX_FREQ, 16'h1CE9, 1'b1},
      '{xcvr_mute_pkg::OFS_RX_FREQ, 16'h1F42, 1'b1},
      '{xcvr_mute_pkg::OFS_TX_FREQ, 16'h2E16, 1'b1},
      '{xcvr_mute_pkg::OFS_TX_FREQ, 16'h2E1D, 1'b0},
      '{xcvr_mute_pkg::OFS_RX_ATT, 16'h0065, 1'b1},
      '{xcvr_mute_pkg::OFS_RX_ATT, 16'h0064, 1'b0},
      '{xcvr_mute_pkg::OFS_TX_ATT, 16'h0064, 1'b0},
      '{xcvr_mute_pkg::OFS_RX_GAIN, 16'h0011, 1'b1},
      '{xcvr_mute_pkg::OFS_RX_GAIN, 16'h0010, 1'b0},
      '{xcvr_mute_pkg::OFS_TX_TILT, 16'h000B, 1'b1},
      '{xcvr_mute_pkg::OFS_TX_TILT, 16'h000A, 1'b0},
      '{xcvr_mute_pkg::OFS_REF, 16'h00FF, 1'b0},
      '{xcvr_mute_pkg::OFS_REF, 16'h0100, 1'b1}};
    foreach (tw[k]) begin
      apb(tw[k].a, 0, 0);
      old = rd;
      apb(tw[k].a, 1, 32'(tw[k].d));
      chk("refused flag", 32'(tw[k].e), 32'(err));
      apb(tw[k].a, 0, 0);
      chk("value kept", tw[k].e ? old : 32'(tw[k].d), rd);
    end
    apb(xcvr_mute_pkg::OFS_STATUS, 1, 0);
    chk("status read-only", 32'h0000_0001, 32'(err));
    apb(8'h34, 0, 0);
    chk("unmapped", 32'h0000_0001, {rd[30:0], err});
    chk("applied ref", 32'h0000_00FF, 32'(setting.ref_trim));
    chk("applied tx freq", 32'h0000_2E1D, 32'(setting.tx_freq));
    chk("applied rx att", 32'h0000_0064, 32'(setting.rx_att));
    $display("refuse done");
  endtask : t_refuse

  task automatic t_strap();
    chk("gain alone", 32'h0000_0000, 32'(setting.rx_gain));
    strap_gnd <= 1'b1;
    tick(8);
    chk("gain redundant", 32'h0000_0010, 32'(setting.rx_gain));
    strap_gnd <= 1'b0;
    tick(8);
    $display("strap done");
  endtask : t_strap

  task automatic t_fault();
    apb(xcvr_mute_pkg::OFS_INT_ST, 0, 0);
    chk("refused event", 32'h0000_0010, rd & 32'h0000_0010);
    apb(xcvr_mute_pkg::OFS_INT_ST, 1, 32'h0000_001F);
    apb(xcvr_mute_pkg::OFS_INT_MSK, 1, 32'h0000_0001);
    rx_bad <= 1'b1;
    tx_bad <= 1'b1;
    tick(8);
    chk("fault drive", 32'h0000_0006, 32'(drive));
    chk("irq up", 32'h0000_0001, 32'(irq));
    apb(xcvr_mute_pkg::OFS_INT_ST, 0, 0);
    chk("fault events", 32'h0000_0003, rd);
    apb(xcvr_mute_pkg::OFS_INT_MSK, 1, 0);
    tick(2);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    apb(xcvr_mute_pkg::OFS_INT_MSK, 1, 32'h0000_0001);
    apb(xcvr_mute_pkg::OFS_INT_ST, 1, 32'h0000_0003);
    tick(2);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    rx_bad <= 1'b0;
    tx_bad <= 1'b0;
    tick(8);
    chk("healthy drive", 32'h0000_001D, 32'(drive));
    ref_unlock <= 1'b1;
    tick(8);
    chk("lock ignored", 32'h0000_0000, 32'(drive.contact_make));
    apb(xcvr_mute_pkg::OFS_CTRL, 1, 32'h0000_00C8);
    tick(6);
    chk("lock alarms", 32'h0000_0001, 32'(drive.contact_make));
    ref_unlock <= 1'b0;
    apb(xcvr_mute_pkg::OFS_CTRL, 1, 32'h0000_0080);
    tick(2);
    chk("amp off", 32'h0000_0004,
        32'({drive.rx_on, drive.tx_on, drive.supply_on}));
    $display("fault done");
  endtask : t_fault

  task automatic t_cancel();
    @(posedge pclk);
    presetn <= 1'b0;
    tick(4);
    presetn <= 1'b1;
    apb(xcvr_mute_pkg::OFS_CTRL, 1, 32'h0000_0009);
    for (int i = 0; i < 12 && drive.rx_on !== 1'b1; i++) @(posedge pclk);
    chk("hold-off cancelled", 32'h0000_0001, 32'(drive.rx_on));
    $display("cancel done");
  endtask : t_cancel

  initial begin
    tick(4);
    presetn <= 1'b1;
    rel = cyc;
    t_holdoff();
    t_retune();
    t_refuse();
    t_strap();
    t_fault();
    t_cancel();
    finish_test();
  end
endmodule : xcvr_mute_ctrl_test
